// ===== verilog/srd_pkg.sv
package srd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Local port decode
  localparam int LRS_W = 2;
  localparam logic [1:0] LRS_DATA = 2'h0;
  localparam logic [1:0] LRS_INDEX = 2'h1;
  localparam logic [1:0] LRS_STATUS = 2'h2;
  localparam int IDX_AUTOINC_BIT = 7;
  localparam logic [6:0] IDX_LOCAL_BASE = 7'h20;
  localparam logic [6:0] IDX_GCFG = 7'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Shared register byte offsets (same on both ports)
  localparam logic [4:0] SH_MBOX_END = 5'h10;
  localparam logic [4:0] SH_LDB_ST = 5'h10;
  localparam logic [4:0] SH_LDB_EN = 5'h11;
  localparam logic [4:0] SH_SDB_ST = 5'h12;
  localparam logic [4:0] SH_SDB_EN = 5'h13;
  localparam int MBOX_BYTES = 16;

  ////////////////////////////////////////////////////////////////////////////
  // System bus slave decode: address bits 11:5 of the XC80-XC9F window
  localparam int EISA_AW = 10;
  localparam int EISA_DW = 32;
  localparam logic [6:0] SLOT_SH_BASE = 7'h64;

  ////////////////////////////////////////////////////////////////////////////
  // Global configuration fields
  localparam int GCFG_SYS_LEVEL = 0;
  localparam int GCFG_LOC_HIGH = 1;
  localparam int GCFG_SYS_EN = 2;
  localparam int GCFG_LOC_EN = 3;
  localparam int GCFG_CH_LSB = 4;
  localparam logic [7:0] GCFG_RST = 8'h00;

  // Local status/control fields
  localparam int STAT_DONE_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {E_IDLE, E_WAIT1, E_WAIT2} srd_eisa_t;

  typedef struct packed {
    logic [MBOX_BYTES-1:0][7:0] mbox;
    logic [7:0] ldb_st;
    logic [7:0] ldb_en;
    logic [7:0] sdb_st;
    logic [7:0] sdb_en;
    logic [7:0] gcfg;
    logic [1:0] done_st;
    logic [1:0] done_prev;
    logic [7:0] index;
    logic last_local;
    srd_eisa_t e_state;
    logic e_wr;
    logic [2:0] e_adr;
    logic [3:0] e_be_n;
    logic [31:0] e_dout;
    logic exrdy;
    logic wb_ack;
    logic [7:0] wb_dout;
    logic s_req;
    logic l_req;
    logic s_rearm;
    logic l_rearm;
    logic s_irq;
    logic s_oe;
    logic l_irq;
  } srd_state_t;

  localparam srd_state_t STATE_RST = '{
    mbox: '0, ldb_st: 8'h00, ldb_en: 8'h00, sdb_st: 8'h00, sdb_en: 8'h00,
    gcfg: GCFG_RST, done_st: 2'h0, done_prev: 2'h0, index: 8'h00,
    last_local: 1'b0, e_state: E_IDLE, e_wr: 1'b0, e_adr: 3'h0,
    e_be_n: 4'hf, e_dout: 32'h0000_0000, exrdy: 1'b1, wb_ack: 1'b0,
    wb_dout: 8'h00, s_req: 1'b0, l_req: 1'b0, s_rearm: 1'b0,
    l_rearm: 1'b0, s_irq: 1'b0, s_oe: 1'b1, l_irq: 1'b1};

endpackage

// ===== verilog/srd_shared_regs.sv
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Shared registers reachable from both ports; local-only and index from local port.
// - On simultaneous shared requests the local processor wins first unless the previous shared grant went to it.
// - Back-to-back contended shared accesses alternate grant between both sides.
// - Local port has 8-bit index and data registers picked by two select lines.
// - Index with bit 7 set advances after each data register access.
// - Local status/control is decoded directly by the two select lines.
// - System I/O at XC80-XC9F maps to shared registers via address and byte enables.
// - Uncontended system slave access takes two clocks plus one wait state.
// - System slave access losing arbitration takes two clocks plus two wait states.
// - Each wait state holds the ready line low for exactly one clock.
// - Two interrupt outputs: one toward system bus, one toward local processor.
// - System interrupt: rising edge in edge mode, active-low open collector in level.
// - Local interrupt polarity programmable; reset selects active low.
// - Local interrupt is always actively driven, never open collector.
// - Trigger and polarity modes are fields of the global configuration register.
// - Each event is masked individually and by a global enable.
// - Only local writes to the system doorbell raise the system interrupt.
// - Local interrupt raised by system writes to the local doorbell and channel transfer completion.
// - Events are edge captured and ORed; later events give no new request.
module srd_shared_regs (
  input wire logic CLK_IN, // Bus clock
  input wire logic NRST_IN, // Async reset, active low
  input wire logic WB_CYC_IN, // Local port Wishbone cycle
  input wire logic WB_STB_IN, // Local port Wishbone strobe
  input wire logic WB_WE_IN, // Local port write
  input wire logic [srd_pkg::LRS_W-1:0] WB_ADR_IN, // Local register select lines
  input wire logic WB_SEL_IN, // Byte lane select
  input wire logic [7:0] WB_DAT_IN, // Local write data
  output logic [7:0] WB_DAT_OUT, // Local read data
  output logic WB_ACK_OUT, // Local access done
  input wire logic EISA_START_IN, // System slave cycle start pulse
  input wire logic EISA_WR_IN, // System slave write
  input wire logic [srd_pkg::EISA_AW-1:0] EISA_ADR_IN, // System address 11:2
  input wire logic [3:0] EISA_BE_N_IN, // System byte enables, low active
  input wire logic [srd_pkg::EISA_DW-1:0] EISA_DAT_IN, // System write data
  output logic [srd_pkg::EISA_DW-1:0] EISA_DAT_OUT, // System read data
  output logic EISA_EXRDY_OUT, // Slave ready, low inserts a wait
  output logic SYS_IRQ_OUT, // System side interrupt level
  output logic SYS_IRQ_OE_OUT, // System side interrupt drive enable
  output logic LOC_IRQ_OUT, // Local side interrupt
  input wire logic [1:0] CH_BUSY_IN, // Channel busy flags
  input wire logic [1:0] XFER_DONE_IN // Channel transfer complete levels
);
  import srd_pkg::*;

  srd_state_t s;
  srd_state_t n;
  logic wb_req;
  logic l_data;
  logic l_shared;
  logic e_req;
  logic e_hit;
  logic conflict;
  logic grant_e;
  logic grant_l;
  logic lexec;
  logic sys_pend;
  logic loc_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Shared register access helpers
  function automatic logic [7:0] sh_read(input srd_state_t st, input logic [4:0] off);
    logic [7:0] r;
    r = 8'h00;
    if (off < SH_MBOX_END) begin
      r = st.mbox[off[3:0]];
    end else begin
      case (off)
        SH_LDB_ST: r = st.ldb_st;
        SH_LDB_EN: r = st.ldb_en;
        SH_SDB_ST: r = st.sdb_st;
        SH_SDB_EN: r = st.sdb_en;
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction

  // Doorbell status: the ringing side sets bits, the serviced side clears them
  function automatic srd_state_t sh_write(input srd_state_t st, input logic [4:0] off,
                                          input logic [7:0] d, input logic from_sys);
    srd_state_t r;
    r = st;
    if (off < SH_MBOX_END) begin
      r.mbox[off[3:0]] = d;
    end else begin
      case (off)
        SH_LDB_ST: begin
          if (from_sys) begin
            r.ldb_st = st.ldb_st | d;
          end else begin
            r.ldb_st = st.ldb_st & ~d;
            r.l_rearm = 1'b1;
          end
        end
        SH_LDB_EN: begin
          r.ldb_en = d;
          r.l_rearm = 1'b1;
        end
        SH_SDB_ST: begin
          if (from_sys) begin
            r.sdb_st = st.sdb_st & ~d;
            r.s_rearm = 1'b1;
          end else begin
            r.sdb_st = st.sdb_st | d;
          end
        end
        SH_SDB_EN: begin
          r.sdb_en = d;
          r.s_rearm = 1'b1;
        end
        default: r = st;
      endcase
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    n.wb_ack = 1'b0;
    n.s_rearm = 1'b0;
    n.l_rearm = 1'b0;

    wb_req = WB_CYC_IN & WB_STB_IN & ~s.wb_ack;
    l_data = wb_req & (WB_ADR_IN == LRS_DATA);
    l_shared = l_data & (s.index[6:0] < IDX_LOCAL_BASE);
    e_req = (s.e_state == E_WAIT1) | (s.e_state == E_WAIT2);
    e_hit = EISA_START_IN & (EISA_ADR_IN[9:3] == SLOT_SH_BASE) & ~(&EISA_BE_N_IN);
    conflict = l_shared & e_req;
    // A second wait always wins, so the system side never loses arbitration twice
    grant_e = e_req & (~l_shared | (s.e_state == E_WAIT2) | s.last_local);
    grant_l = l_shared & ~grant_e;
    lexec = wb_req & (~l_shared | grant_l);

    sys_pend = s.gcfg[GCFG_SYS_EN] & (|(s.sdb_st & s.sdb_en));
    loc_pend = s.gcfg[GCFG_LOC_EN] & ((|(s.ldb_st & s.ldb_en)) |
               (|(s.done_st & s.gcfg[GCFG_CH_LSB +: 2])));

    if (grant_l) begin
      n.last_local = 1'b1;
    end else if (grant_e) begin
      n.last_local = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Local port
    if (lexec) begin
      n.wb_ack = 1'b1;
      case (WB_ADR_IN)
        LRS_DATA: begin
          // Index selects the target, data moves through here
          if (s.index[6:0] < IDX_LOCAL_BASE) begin
            n.wb_dout = sh_read(s, s.index[4:0]);
            if (WB_WE_IN && WB_SEL_IN) begin
              n = sh_write(n, s.index[4:0], WB_DAT_IN, 1'b0);
            end
          end else if (s.index[6:0] == IDX_GCFG) begin
            n.wb_dout = s.gcfg;
            if (WB_WE_IN && WB_SEL_IN) begin
              n.gcfg = WB_DAT_IN;
            end
          end else begin
            n.wb_dout = 8'h00;
          end
          if (s.index[IDX_AUTOINC_BIT]) begin
            n.index = {1'b1, s.index[6:0] + 7'h01};
          end
        end
        LRS_INDEX: begin
          n.wb_dout = s.index;
          if (WB_WE_IN && WB_SEL_IN) begin
            n.index = WB_DAT_IN;
          end
        end
        LRS_STATUS: begin
          n.wb_dout = {1'b0, s.l_req, s.done_st, 2'b00, CH_BUSY_IN};
          if (WB_WE_IN && WB_SEL_IN) begin
            n.done_st = s.done_st & ~WB_DAT_IN[STAT_DONE_LSB +: 2];
            n.l_rearm = 1'b1;
          end
        end
        default: n.wb_dout = 8'h00;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // System bus slave
    case (s.e_state)
      E_IDLE: begin
        if (e_hit) begin
          n.e_state = E_WAIT1;
          n.e_wr = EISA_WR_IN;
          n.e_adr = EISA_ADR_IN[2:0];
          n.e_be_n = EISA_BE_N_IN;
        end
      end
      E_WAIT1, E_WAIT2: begin
        if (grant_e) begin
          n.e_state = E_IDLE;
          for (int b = 0; b < 4; b++) begin
            if (!s.e_be_n[b]) begin
              n.e_dout[8*b +: 8] = sh_read(s, {s.e_adr, 2'(b)});
              if (s.e_wr) begin
                n = sh_write(n, {s.e_adr, 2'(b)}, EISA_DAT_IN[8*b +: 8], 1'b1);
              end
            end
          end
        end else begin
          n.e_state = E_WAIT2;
        end
      end
      default: n.e_state = E_IDLE;
    endcase
    n.exrdy = (n.e_state == E_IDLE);

    //////////////////////////////////////////////////////////////////////////
    // Channel completion edges; a set wins over a same-cycle clear
    n.done_prev = XFER_DONE_IN;
    n.done_st = n.done_st | (XFER_DONE_IN & ~s.done_prev);

    //////////////////////////////////////////////////////////////////////////
    // Interrupt requests, dropped for one cycle after a clear or re-enable
    n.s_req = sys_pend & ~s.s_rearm;
    n.l_req = loc_pend & ~s.l_rearm;
    n.s_irq = n.gcfg[GCFG_SYS_LEVEL] ? 1'b0 : n.s_req;
    n.s_oe = n.gcfg[GCFG_SYS_LEVEL] ? n.s_req : 1'b1;
    n.l_irq = n.l_req ~^ n.gcfg[GCFG_LOC_HIGH];
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign WB_DAT_OUT = s.wb_dout;
  assign WB_ACK_OUT = s.wb_ack;
  assign EISA_DAT_OUT = s.e_dout;
  assign EISA_EXRDY_OUT = s.exrdy;
  assign SYS_IRQ_OUT = s.s_irq;
  assign SYS_IRQ_OE_OUT = s.s_oe;
  assign LOC_IRQ_OUT = s.l_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_slave_start: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.e_state == E_IDLE && e_hit) |=> !EISA_EXRDY_OUT)
    else $error("Wait state not inserted after slave start");

  a_slave_fast: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.e_state == E_WAIT1 && grant_e) |=> EISA_EXRDY_OUT)
    else $error("Uncontended slave access took more than one wait");

  a_slave_lost: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.e_state == E_WAIT1 && !grant_e) |=> !EISA_EXRDY_OUT ##1 EISA_EXRDY_OUT)
    else $error("Lost slave access did not take exactly two waits");

  a_wait_bclk: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    $fell(EISA_EXRDY_OUT) |-> ##[1:2] EISA_EXRDY_OUT)
    else $error("Ready held low longer than two clocks");

  a_local_first: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (conflict && !s.last_local && s.e_state == E_WAIT1) |-> grant_l && !grant_e)
    else $error("Local port lost a fresh contention");

  a_rotate_grant: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (conflict && s.last_local) |-> grant_e && !grant_l)
    else $error("Grant did not alternate");

  a_index_step: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (lexec && WB_ADR_IN == LRS_DATA && s.index[IDX_AUTOINC_BIT]) |=>
    (s.index[6:0] == $past(s.index[6:0]) + 7'h01) && s.index[IDX_AUTOINC_BIT])
    else $error("Index did not advance");

  a_loc_polarity: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    LOC_IRQ_OUT == (s.l_req ~^ s.gcfg[GCFG_LOC_HIGH]))
    else $error("Local interrupt polarity wrong");

  a_sys_level_oc: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    s.gcfg[GCFG_SYS_LEVEL] |-> !SYS_IRQ_OUT && (SYS_IRQ_OE_OUT == s.s_req))
    else $error("System interrupt not open collector in level mode");

  a_sys_cause: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    $rose(s.s_req) |-> $past(sys_pend) && s.gcfg[GCFG_SYS_EN] == $past(s.gcfg[GCFG_SYS_EN]))
    else $error("System interrupt raised without enabled doorbell");

  a_mask_gate: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !s.gcfg[GCFG_LOC_EN] |=> !s.l_req)
    else $error("Globally disabled local interrupt asserted");

  a_rearm_drop: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.l_rearm && loc_pend) |=> !s.l_req ##1 s.l_req)
    else $error("Local request not re-raised after rearm");

  a_ack_one_cycle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("Local acknowledge held longer than one cycle");

  a_ack_follows: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    lexec |=> WB_ACK_OUT)
    else $error("Executed local access not acknowledged");

  a_local_bounded: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (wb_req && !lexec) |=> (lexec || !WB_STB_IN))
    else $error("Local access held off for more than one cycle");

  a_grant_excl: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !(grant_e && grant_l))
    else $error("Both sides granted in one cycle");

  a_idle_ready: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.e_state == E_IDLE) |-> EISA_EXRDY_OUT)
    else $error("Ready low with no slave cycle pending");

  a_miss_ignored: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.e_state == E_IDLE && EISA_START_IN && !e_hit) |=>
    (EISA_EXRDY_OUT && s.e_state == E_IDLE))
    else $error("Slave cycle started outside the shared window");

  a_busy_ignored: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (s.e_state != E_IDLE && EISA_START_IN) |=> s.e_state != E_WAIT1)
    else $error("Start accepted while a slave cycle was pending");

  a_sys_only_db: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    s.s_req |-> $past(|(s.sdb_st & s.sdb_en)))
    else $error("System request without enabled system doorbell");

  a_loc_source: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    s.l_req |-> $past((|(s.ldb_st & s.ldb_en)) ||
    (|(s.done_st & s.gcfg[GCFG_CH_LSB +: 2]))))
    else $error("Local request without doorbell or channel event");

  a_done_edge0: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (XFER_DONE_IN[0] && !s.done_prev[0]) |=> s.done_st[0])
    else $error("Channel 0 completion edge not captured");

  a_done_edge1: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (XFER_DONE_IN[1] && !s.done_prev[1]) |=> s.done_st[1])
    else $error("Channel 1 completion edge not captured");

  a_autoinc_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (lexec && WB_ADR_IN == LRS_DATA && !s.index[IDX_AUTOINC_BIT]) |=> $stable(s.index))
    else $error("Index moved with auto increment off");

  a_sel_refused: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (lexec && WB_ADR_IN == LRS_INDEX && !WB_SEL_IN) |=> $stable(s.index))
    else $error("Index written with byte lane deselected");

  a_sys_edge_mode: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !s.gcfg[GCFG_SYS_LEVEL] |-> (SYS_IRQ_OE_OUT && (SYS_IRQ_OUT == s.s_req)))
    else $error("System interrupt not driven in edge mode");

  a_eisa_no_cfg: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (grant_e && !lexec) |=> ($stable(s.gcfg) && $stable(s.index)))
    else $error("System access reached a local only register");

  a_gcfg_local: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    $changed(s.gcfg) |-> $past(lexec && WB_WE_IN && WB_ADR_IN == LRS_DATA &&
    s.index[6:0] == IDX_GCFG))
    else $error("Global configuration changed without local write");

  a_sys_mask_gate: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !s.gcfg[GCFG_SYS_EN] |=> !s.s_req)
    else $error("Globally disabled system interrupt asserted");

  a_held_request: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (loc_pend && !s.l_rearm) |=> s.l_req)
    else $error("Local request dropped while still pending");

endmodule // srd_shared_regs

// ===== sim/srd_eisa_master.sv
`timescale 1ns/1ps
module srd_eisa_master (
  input wire logic CLK_IN, // Bus clock
  input wire logic [31:0] RD_IN, // Slave read data
  input wire logic RDY_IN, // Slave ready
  output logic START_OUT, // Cycle start
  output logic WR_OUT, // Write cycle
  output logic [9:0] ADR_OUT, // Address 11:2
  output logic [3:0] BE_N_OUT, // Byte enables
  output logic [31:0] DAT_OUT // Write data
);
  initial begin
    START_OUT = 1'b0;
    WR_OUT = 1'b0;
    ADR_OUT = 10'h000;
    BE_N_OUT = 4'hf;
    DAT_OUT = 32'h0000_0000;
  end
  // Held until ready is seen, then released to inverted values
  task automatic io(input logic wr, input logic [9:0] a, input logic [3:0] be,
                    input logic [31:0] d, output logic [31:0] rd, output int w);
    @(posedge CLK_IN);
    START_OUT <= 1'b1;
    WR_OUT <= wr;
    ADR_OUT <= a;
    BE_N_OUT <= be;
    DAT_OUT <= d;
    @(posedge CLK_IN);
    START_OUT <= 1'b0;
    w = 0;
    @(posedge CLK_IN);
    while (RDY_IN !== 1'b1) begin
      w++;
      @(posedge CLK_IN);
    end
    rd = RD_IN;
    ADR_OUT <= ~a;
    BE_N_OUT <= ~be;
    DAT_OUT <= ~d;
  endtask
endmodule // srd_eisa_master

// ===== sim/srd_shared_regs_tb_top.sv
`timescale 1ns/1ps
module srd_shared_regs_tb_top;
  import srd_pkg::*;
  logic clk, nrst, cyc, stb, we, sel;
  logic [1:0] adr, busy, done;
  logic [7:0] wd, rdat;
  logic ack, st, ewr, rdy, sirq, soe, lirq;
  logic [9:0] ea;
  logic [3:0] ebe;
  logic [31:0] ewd, erd, rb, re;
  logic [7:0] g;
  int num_errors = 0;
  int n_compared = 0;
  int lat, w;
  logic lane;

  srd_shared_regs u_srd_shared_regs (.CLK_IN(clk), .NRST_IN(nrst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wd),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .EISA_START_IN(st), .EISA_WR_IN(ewr),
    .EISA_ADR_IN(ea), .EISA_BE_N_IN(ebe), .EISA_DAT_IN(ewd), .EISA_DAT_OUT(erd),
    .EISA_EXRDY_OUT(rdy), .SYS_IRQ_OUT(sirq), .SYS_IRQ_OE_OUT(soe), .LOC_IRQ_OUT(lirq),
    .CH_BUSY_IN(busy), .XFER_DONE_IN(done));
  srd_eisa_master u_srd_eisa_master (.CLK_IN(clk), .RD_IN(erd), .RDY_IN(rdy),
    .START_OUT(st), .WR_OUT(ewr), .ADR_OUT(ea), .BE_N_OUT(ebe), .DAT_OUT(ewd));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Classic single cycle; lat counts edges until ack is seen
  task automatic wb(input logic w_e, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_e;
    sel <= lane;
    adr <= a;
    wd <= d;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (ack !== 1'b1);
    rb = {24'h00_0000, rdat};
    cyc <= 1'b0;
    stb <= 1'b0;
    wd <= ~d;
  endtask
  task automatic wr_idx(input logic [7:0] i, input logic [7:0] v);
    wb(1'b1, LRS_INDEX, i);
    wb(1'b1, LRS_DATA, v);
  endtask
  task automatic rd_idx(input logic [7:0] i, input logic [7:0] exp);
    wb(1'b1, LRS_INDEX, i);
    wb(1'b0, LRS_DATA, 8'h00);
    chk(rb, {24'h00_0000, exp});
  endtask
  task automatic eio(input logic wr, input logic [2:0] dw, input logic [3:0] be,
                     input logic [31:0] d);
    u_srd_eisa_master.io(wr, {SLOT_SH_BASE, dw}, be, d, re, w);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    idle(1);
    chk({rdy, sirq, soe, lirq}, 4'hb);
    rd_idx(g, GCFG_RST);
  endtask
  task automatic t_arb();
    wb(1'b1, LRS_INDEX, 8'h00);
    // Local request lands while the slave cycle waits, so they really contend
    fork
      eio(1'b1, 3'h2, 4'h0, 32'h0000_0000);
      begin
        @(posedge clk);
        wb(1'b0, LRS_DATA, 8'h00);
      end
    join
    chk(w, 2);
    chk(lat, 2);
    // A lone local grant makes the system side next in turn
    wb(1'b0, LRS_DATA, 8'h00);
    fork
      eio(1'b1, 3'h2, 4'h0, 32'h0000_0000);
      begin
        @(posedge clk);
        wb(1'b0, LRS_DATA, 8'h00);
      end
    join
    chk(w, 1);
    chk(lat, 3);
  endtask
  task automatic t_index();
    wr_idx(8'h03, 8'ha5);
    rd_idx(8'h03, 8'ha5);
    lane = 1'b0;
    wb(1'b1, LRS_INDEX, 8'h25);
    lane = 1'b1;
    wb(1'b0, LRS_INDEX, 8'h00);
    chk(rb, 32'h0000_0003);
    wr_idx(8'h25, 8'h77);
    rd_idx(8'h25, 8'h00);
    wb(1'b0, LRS_INDEX, 8'h00);
    chk(rb, 32'h0000_0025);
    wb(1'b0, 2'h3, 8'h00);
    chk(rb, 32'h0000_0000);
  endtask
  task automatic t_autoinc();
    wb(1'b1, LRS_INDEX, 8'h86);
    for (int i = 0; i < 4; i++) wb(1'b1, LRS_DATA, 8'h50 + 8'(i));
    wb(1'b1, LRS_INDEX, 8'h86);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, LRS_DATA, 8'h00);
      chk(rb, 32'h0000_0050 + i);
    end
    wb(1'b0, LRS_INDEX, 8'h00);
    chk(rb, 32'h0000_008a);
  endtask
  task automatic t_eisa();
    eio(1'b1, 3'h0, 4'h0, 32'h4433_2211);
    chk(w, 1);
    for (int i = 0; i < 4; i++) rd_idx(8'(i), 8'(8'h11 * (i + 1)));
    eio(1'b1, 3'h0, 4'hd, 32'h0000_ee00);
    eio(1'b0, 3'h0, 4'h0, 32'h0000_0000);
    chk(re, 32'h4433_ee11);
    eio(1'b0, 3'h1, 4'h0, 32'h0000_0000);
    chk(re, 32'h5150_0000);
    u_srd_eisa_master.io(1'b0, {7'h65, 3'h0}, 4'h0, 32'h0000_0000, re, w);
    chk(w, 0);
    @(posedge clk);
    busy <= 2'b10;
    wb(1'b0, LRS_STATUS, 8'h00);
    chk(rb, 32'h0000_0002);
  endtask
  task automatic t_sys();
    wr_idx(g, 8'h04);
    wr_idx(8'h12, 8'h01);
    idle(4);
    chk({sirq, soe}, 2'b01);
    wr_idx(8'h13, 8'h01);
    idle(4);
    chk({sirq, soe}, 2'b11);
    wr_idx(g, 8'h00);
    idle(4);
    chk({sirq, soe}, 2'b01);
    wr_idx(g, 8'h05);
    idle(4);
    chk({sirq, soe}, 2'b01);
    eio(1'b1, 3'h4, 4'hb, 32'h0001_0000);
    idle(4);
    chk({sirq, soe}, 2'b00);
  endtask
  task automatic t_loc();
    int n;
    wr_idx(g, 8'h0d);
    wr_idx(8'h11, 8'h03);
    eio(1'b1, 3'h4, 4'he, 32'h0000_0001);
    idle(4);
    chk({sirq, soe, lirq}, 3'b000);
    eio(1'b1, 3'h4, 4'he, 32'h0000_0002);
    idle(4);
    chk(lirq, 1'b0);
    wr_idx(8'h11, 8'h00);
    rd_idx(8'h10, 8'h03);
    wr_idx(8'h10, 8'h01);
    wr_idx(8'h11, 8'h03);
    n = 0;
    repeat (6) begin
      @(negedge clk);
      if (lirq === 1'b1) n++;
    end
    chk(n, 1);
    wr_idx(8'h10, 8'h02);
    idle(4);
    chk(lirq, 1'b1);
  endtask
  task automatic t_done();
    wr_idx(g, 8'h1a);
    idle(4);
    chk(lirq, 1'b0);
    @(posedge clk);
    done <= 2'b01;
    @(posedge clk);
    done <= 2'b00;
    idle(4);
    chk(lirq, 1'b1);
    wb(1'b1, LRS_STATUS, 8'h10);
    idle(4);
    chk(lirq, 1'b0);
    @(posedge clk);
    done <= 2'b10;
    idle(4);
    chk(lirq, 1'b0);
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    g = {1'b0, IDX_GCFG};
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 1'b1;
    lane = 1'b1;
    adr = 2'h0;
    wd = 8'h00;
    busy = 2'b00;
    done = 2'b00;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_arb();
    t_index();
    t_autoinc();
    t_eisa();
    t_sys();
    t_loc();
    t_done();
    end_of_test();
  end
endmodule // srd_shared_regs_tb_top
